// ==== bst_tap.sv ====
/*
 Boundary-scan test access port: TAP state machine, two-bit instruction
 register, bypass register and 169-cell boundary chain.
 Also holds the two-stage pin synchroniser that the port uses.
 Assumes test pins are asynchronous to clk_i, which is much faster than tck.
*/
`timescale 1ns/1ps
// Behaviour
// RULE1 - Sample mode select on test clock rise
// RULE2 - Capture test data in on rise
// RULE3 - Route data in to IR or DR
// RULE4 - Change test data out on fall
// RULE5 - Output high impedance when not shifting
// RULE6 - Test reset clears TAP and IR
// RULE7 - Undriven select and data read high
// RULE8 - Test logic separate from core logic
// RULE9 - Two-bit IR loaded in Shift-IR
// RULE10 - Decode 00 EXTEST, 11 BYPASS, else SAMPLE
// RULE11 - Instruction selects data register path
// RULE12 - Only boundary chain and bypass registers
// RULE13 - Bypass is one-bit delay path
// RULE14 - Chain bits 0..168, bit 0 first
// RULE15 - Control cell one enables driver
// RULE16 - Standard sixteen-state TAP machine
// RULE17 - Five high selects reach reset
module bst_tap
   import bst_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                tck_i,
   input  wire logic                tms_i,
   input  wire logic                tdi_i,
   input  wire logic                trst_n_i,
   input  wire logic [BSR_LEN-1:0]  pin_in_i,
   output logic                     tdo_o,
   output logic                     tdo_oe_n_o,
   output logic                     extest_o,
   output logic [BSR_LEN-1:0]       bsr_upd_o
);
   // ==========================================================
   // Synchronisers; pull-ups are outside, an open pin reads high
   logic tck_s;
   logic tms;
   logic tdi;
   logic trst_n;

   // Test clock idles low, so its stages reset low: no false edge
   bst_sync #(
      .RST_VAL (TCK_REST_LVL)
   ) u_sync_tck (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (tck_i),
      .q_o     (tck_s)
   );

   bst_sync #(
      .RST_VAL (PIN_PULL_LVL)
   ) u_sync_tms (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (tms_i),   // see RULE7
      .q_o     (tms)
   );

   bst_sync #(
      .RST_VAL (PIN_PULL_LVL)
   ) u_sync_tdi (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (tdi_i),   // see RULE7
      .q_o     (tdi)
   );

   // Open test reset pin reads high, so the port is not held in reset
   bst_sync #(
      .RST_VAL (PIN_PULL_LVL)
   ) u_sync_trst (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (trst_n_i),   // see RULE6
      .q_o     (trst_n)
   );

   // ==========================================================
   // Test clock edges; same sync depth keeps tms and tdi aligned
   logic tck_old_q;
   logic tck_old_d;
   logic tck_rise;
   logic tck_fall;

   always_comb begin
      tck_old_d = tck_s;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tck_old_q <= TCK_REST_LVL;
      end else begin
         tck_old_q <= tck_old_d;
      end
   end

   // Limitation: each tck level must last two clk_i periods or more
   assign tck_rise = tck_s & ~tck_old_q;   // see RULE8
   assign tck_fall = ~tck_s & tck_old_q;

   // ==========================================================
   // TAP state machine
   bst_state_t state_q;
   bst_state_t state_d;

   always_comb begin
      state_d = state_q;
      // Test reset wins over any tck edge
      if (!trst_n) begin
         state_d = TLR;   // see RULE6
      end else if (tck_rise) begin   // see RULE1
         case (state_q)   // see RULE16, RULE17
            TLR:    state_d = tms ? TLR    : RTI;
            RTI:    state_d = tms ? SEL_DR : RTI;
            SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
            CAP_DR: state_d = tms ? EX1_DR : SH_DR;
            SH_DR:  state_d = tms ? EX1_DR : SH_DR;
            EX1_DR: state_d = tms ? UPD_DR : PAU_DR;
            PAU_DR: state_d = tms ? EX2_DR : PAU_DR;
            EX2_DR: state_d = tms ? UPD_DR : SH_DR;
            UPD_DR: state_d = tms ? SEL_DR : RTI;
            SEL_IR: state_d = tms ? TLR    : CAP_IR;
            CAP_IR: state_d = tms ? EX1_IR : SH_IR;
            SH_IR:  state_d = tms ? EX1_IR : SH_IR;
            EX1_IR: state_d = tms ? UPD_IR : PAU_IR;
            PAU_IR: state_d = tms ? EX2_IR : PAU_IR;
            EX2_IR: state_d = tms ? UPD_IR : SH_IR;
            UPD_IR: state_d = tms ? SEL_DR : RTI;
            default: state_d = TLR;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Instruction, bypass and boundary registers
   logic [IR_W-1:0]    ir_sh_q;
   logic [IR_W-1:0]    ir_sh_d;
   logic [IR_W-1:0]    ir_q;
   logic [IR_W-1:0]    ir_d;
   logic               byp_q;
   logic               byp_d;
   logic [BSR_LEN-1:0] bsr_sh_q;
   logic [BSR_LEN-1:0] bsr_sh_d;
   logic [BSR_LEN-1:0] upd_q;
   logic [BSR_LEN-1:0] upd_d;
   logic               sel_byp;

   assign sel_byp = (ir_q == INS_BYPASS);   // see RULE10, RULE11

   always_comb begin
      ir_sh_d  = ir_sh_q;
      ir_d     = ir_q;
      byp_d    = byp_q;
      bsr_sh_d = bsr_sh_q;
      upd_d    = upd_q;
      // Instruction falls back to bypass whenever the port is reset
      if (!trst_n || (state_q == TLR)) begin
         ir_d = IR_RESET;   // see RULE6
      end else if (tck_rise) begin   // see RULE2, RULE3
         case (state_q)
            CAP_IR: ir_sh_d = IR_CAPTURE;
            SH_IR:  ir_sh_d = {tdi, ir_sh_q[IR_W-1:1]};   // see RULE9
            UPD_IR: ir_d    = ir_sh_q;
            CAP_DR: begin
               // Bypass stage always captures zero
               byp_d = 1'h0;
               if (!sel_byp) begin
                  bsr_sh_d = pin_in_i;   // see RULE12
               end
            end
            SH_DR: begin
               if (sel_byp) begin
                  byp_d = tdi;   // see RULE13
               end else begin
                  bsr_sh_d = {tdi, bsr_sh_q[BSR_LEN-1:1]};   // see RULE14
               end
            end
            UPD_DR: begin
               // Pin values move only here, never while shifting
               if (!sel_byp) begin
                  upd_d = bsr_sh_q;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_sh_q  <= '0;
         ir_q     <= IR_RESET;
         byp_q    <= 1'h0;
         bsr_sh_q <= '0;
         upd_q    <= '0;
      end else begin
         ir_sh_q  <= ir_sh_d;
         ir_q     <= ir_d;
         byp_q    <= byp_d;
         bsr_sh_q <= bsr_sh_d;
         upd_q    <= upd_d;
      end
   end

   // ==========================================================
   // Test data out, changed only on the falling test clock edge
   logic tdo_q;
   logic tdo_d;
   logic oe_n_q;
   logic oe_n_d;
   logic ext_q;
   logic ext_d;

   always_comb begin
      tdo_d  = tdo_q;
      oe_n_d = oe_n_q;
      // Core sees the new instruction one clk after its update
      ext_d  = (ir_q == INS_EXTEST);   // see RULE10
      if (!trst_n) begin
         // Driver released at once, without waiting for a tck edge
         oe_n_d = 1'h1;
      end else if (tck_fall) begin   // see RULE4
         oe_n_d = !((state_q == SH_IR) || (state_q == SH_DR));   // see RULE5
         if (state_q == SH_IR) begin
            tdo_d = ir_sh_q[0];
         end else if (sel_byp) begin
            tdo_d = byp_q;
         end else begin
            tdo_d = bsr_sh_q[0];   // see RULE14
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tdo_q  <= 1'h0;
         oe_n_q <= 1'h1;
         ext_q  <= 1'h0;
      end else begin
         tdo_q  <= tdo_d;
         oe_n_q <= oe_n_d;
         ext_q  <= ext_d;
      end
   end

   // Control cells pass through as stored; a one enables its driver
   assign tdo_o      = tdo_q;
   assign tdo_oe_n_o = oe_n_q;
   assign extest_o   = ext_q;
   assign bsr_upd_o  = upd_q;   // see RULE15
endmodule : bst_tap

// ==========================================================
// Two-stage synchroniser for one asynchronous pin
module bst_sync
   import bst_pkg::*;
#(
   parameter logic RST_VAL = 1'h0
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic [SYNC_W-1:0] sync_q;
   logic [SYNC_W-1:0] sync_d;

   always_comb begin
      sync_d = {sync_q[SYNC_W-2:0], d_i};
   end

   // Reset to the pin's idle level, so no false edge follows reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q <= {SYNC_W{RST_VAL}};
      end else begin
         sync_q <= sync_d;
      end
   end

   // First stage may go metastable; only the last stage leaves
   assign q_o = sync_q[SYNC_W-1];
endmodule : bst_sync

// ==== bst_pkg.sv ====
/*
 Boundary-scan test port package: TAP states, instruction codes, chain sizes.
 Assumes the test clock is sampled by a faster system clock.
*/
package bst_pkg;
   // ==========================================================
   // TAP controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } bst_state_t;
   // ==========================================================
   // Instruction codes
   localparam int          IR_W        = 2;
   localparam logic [1:0]  INS_EXTEST  = 2'h0;
   localparam logic [1:0]  INS_BYPASS  = 2'h3;
   localparam logic [1:0]  IR_CAPTURE  = 2'h1;
   localparam logic [1:0]  IR_RESET    = INS_BYPASS;
   // ==========================================================
   // Boundary chain, synchroniser depth and pin rest levels
   localparam int          BSR_LEN     = 169;
   localparam int          SYNC_W      = 2;
   localparam logic        PIN_PULL_LVL = 1'h1;
   localparam logic        TCK_REST_LVL = 1'h0;
endpackage : bst_pkg

// ==== bst_tap_asserts.sv ====
/* Port checker for bst_tap. Assumes bind to bst_tap, one clock domain. */
`timescale 1ns/1ps
module bst_tap_asserts
   import bst_pkg::*;
(
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   input wire logic               tck_i,
   input wire logic               trst_n_i,
   input wire logic               tdo_o,
   input wire logic               tdo_oe_n_o,
   input wire logic               extest_o,
   input wire logic [BSR_LEN-1:0] bsr_upd_o
);
   // ======
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   rst_val_a: assert property (disable iff (1'h0) !rst_n_i |-> tdo_oe_n_o && !extest_o)
      else $error("reset values");
   trst_oe_a: assert property (!trst_n_i [*6] |-> tdo_oe_n_o) else $error("oe in trst");
   trst_ir_a: assert property (!trst_n_i [*6] |-> !extest_o) else $error("ir in trst");
   oe_trst_a: assert property (!tdo_oe_n_o |-> $past(trst_n_i, 6)) else $error("oe late");
   oe_stand_a: assert property ($fell(tdo_oe_n_o) |-> ##1 !tdo_oe_n_o [*8])
      else $error("oe short");
   // Slow tck: output moves only while tck has been low a while
   tdo_fall_a: assert property (disable iff (!rst_n_i || !trst_n_i)
      $changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2)) else $error("tdo edge");
   oe_fall_a: assert property (disable iff (!rst_n_i || !trst_n_i)
      $changed(tdo_oe_n_o) |-> !$past(tck_i)) else $error("oe edge");
   upd_rise_a: assert property ($changed(bsr_upd_o) |-> tck_i) else $error("upd edge");
   ir_rise_a: assert property (disable iff (!rst_n_i || !trst_n_i)
      $changed(extest_o) |-> tck_i) else $error("ir edge");
   cover property ($fell(tdo_oe_n_o));
   cover property ($rose(extest_o));
   cover property ($changed(bsr_upd_o));
endmodule : bst_tap_asserts
bind bst_tap bst_tap_asserts u_chk (.clk_i, .rst_n_i, .tck_i, .trst_n_i, .tdo_o,
   .tdo_oe_n_o, .extest_o, .bsr_upd_o);

// ==== bst_jtag_host.sv ====
/* Test controller model. Assumes clk_i only paces it; tck rests between steps. */
`timescale 1ns/1ps
module bst_jtag_host (
   input  wire logic clk_i,
   input  wire logic tdo_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   output logic      trst_n_o
);
   // ======
   // Mode, data and reset pins idle high, as the pull-ups leave them; tck idles low
   initial begin
      tck_o = 1'h0;
      tms_o = 1'h1;
      tdi_o = 1'h1;
      trst_n_o = 1'h1;
   end
   // One 130 ns tck cycle; tdo is read just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tck_o = 1'h0;
      tms_o = m;
      tdi_o = d;
      repeat (7) @(negedge clk_i);
      q = tdo_i;
      tck_o = 1'h1;
      repeat (6) @(negedge clk_i);
   endtask : step
   task automatic pulse_trst();
      trst_n_o = 1'h0;
      repeat (10) @(negedge clk_i);
      trst_n_o = 1'h1;
      repeat (4) @(negedge clk_i);
   endtask : pulse_trst
endmodule : bst_jtag_host

// ==== tb_bst_tap.sv ====
/* Bench for bst_tap. Assumes bst_jtag_host acts as test controller. */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_bst_tap
   import bst_pkg::*;
;
   logic               clk_i, rst_n_i, tck, tms, tdi, trst_n, tdo, oe_n, ext;
   logic [BSR_LEN-1:0] pins, upd, dq;
   int                 mismatches, compares;
   bst_tap DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .trst_n_i(trst_n), .pin_in_i(pins), .tdo_o(tdo),
      .tdo_oe_n_o(oe_n), .extest_o(ext), .bsr_upd_o(upd));
   bst_jtag_host u_host (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi), .trst_n_o(trst_n));
   // ======
   // Scans start and end in Run-Test/Idle
   task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] d);
      logic q;
      dq = '0;
      u_host.step(1'h1, 1'h1, q);
      if (ir) u_host.step(1'h1, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      for (int i = 0; i < n; i++) begin
         u_host.step(i == n - 1, d[i], q);
         dq[i] = q;
         `CHK(oe_n, 1'h0)
      end
      u_host.step(1'h1, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      `CHK(oe_n, 1'h1)
   endtask : scan
   task automatic load_ir(input logic [1:0] c);
      scan(1'h1, IR_W, BSR_LEN'(c));
      `CHK(dq[1:0], IR_CAPTURE)
   endtask : load_ir
   task automatic t_codes();
      pins = BSR_LEN'(4'h9);
      for (int c = 0; c < 4; c++) begin
         load_ir(c[1:0]);
         `CHK(ext, c == 0)
         scan(1'h0, 4, '0);
         `CHK(dq[3:0], (c == 3) ? 4'h0 : 4'h9)
      end
   endtask : t_codes
   task automatic t_bypass();
      load_ir(INS_BYPASS);
      scan(1'h0, 4, BSR_LEN'(4'hD));
      `CHK(dq[3:0], 4'hA)
   endtask : t_bypass
   task automatic t_chain();
      load_ir(INS_EXTEST);
      pins = BSR_LEN'({6{32'hA5C30F96}});
      scan(1'h0, BSR_LEN, ~pins);
      `CHK(dq, pins)
      `CHK(upd, ~pins)
   endtask : t_chain
   task automatic t_resets();
      logic q;
      `CHK(ext, 1'h1)
      u_host.step(1'h1, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      for (int i = 0; i < 5; i++) u_host.step(1'h1, 1'h1, q);
      `CHK(ext, 1'h0)
      u_host.step(1'h0, 1'h1, q);
      load_ir(INS_EXTEST);
      u_host.step(1'h1, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      u_host.step(1'h0, 1'h1, q);
      `CHK(oe_n, 1'h0)
      u_host.pulse_trst();
      `CHK(ext, 1'h0)
      `CHK(oe_n, 1'h1)
      u_host.step(1'h0, 1'h1, q);
      load_ir(INS_EXTEST);
      `CHK(ext, 1'h1)
   endtask : t_resets
   task automatic final_report();
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      logic q;
      rst_n_i = 1'h1;
      pins = '0;
      mismatches = 0;
      compares = 0;
      #1 rst_n_i = 1'h0;
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'h1;
      repeat (3) @(negedge clk_i);
      `CHK(ext, 1'h0)
      u_host.step(1'h0, 1'h1, q);
      t_codes();
      t_bypass();
      t_chain();
      t_resets();
      final_report();
   end
   initial begin
      #500us;
      mismatches++;
      final_report();
   end
endmodule : tb_bst_tap
